// ===== design/frps_pkg.sv
`default_nettype none
package frps_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  KEY_OFS        = 8'h04;
    localparam logic [7:0]  PAGE_OFS       = 8'h08;
    localparam logic [7:0]  STATUS_OFS     = 8'h0C;

    // ==========================================================
    // Control fields
    localparam int          OP_LSB         = 0;
    localparam int          ERASE_BIT      = 6;
    localparam int          MODIFY_EN_BIT  = 14;
    localparam int          START_BIT      = 15;
    localparam logic [3:0]  OP_ERASE_PAGE  = 4'h2;
    localparam logic [3:0]  OP_PROGRAM_ROW = 4'h1;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_WR_MASK   = 16'h404F;
    localparam logic [7:0]  PAGE_RESET     = 8'h00;

    // ==========================================================
    // Unlock keys
    localparam logic [7:0]  KEY_FIRST      = 8'h55;
    localparam logic [7:0]  KEY_SECOND     = 8'hAA;

    // ==========================================================
    // Geometry and timing
    localparam int          ROW_WORDS      = 64;
    localparam int          PAGE_ROWS      = 8;
    localparam int          CLK_MHZ        = 25;
    localparam int          ERASE_TIME_US  = 20;
    localparam int          PROG_TIME_US   = 2;
    localparam int          ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;

    // ==========================================================
    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b10
    } frps_key_e;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ERASE = 2'b01,
        SEQ_PROG  = 2'b10
    } frps_seq_e;

endpackage : frps_pkg
`default_nettype wire

// ===== design/frps_timer.sv
`timescale 1ns/1ps
`default_nettype none
module frps_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic             done_reg;
    logic             done_next;

    always_comb
    begin
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (load)
        begin
            cnt_next = count;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next  = cnt_reg - 1'b1;
            done_next = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign busy = (cnt_reg != '0);
    assign done = done_reg;
endmodule : frps_timer
`default_nettype wire

// ===== design/frps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module frps_sequencer #(
    parameter int ERASE_CYCLES = frps_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES  = frps_pkg::PROG_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cpu_stall,
    output logic             flash_erase_page,
    output logic             flash_program_row,
    output logic [7:0]       flash_page
);
    // ==========================================================
    // Bus channel capture, register and sequencer state
    logic [7:0]  awaddr_reg,  awaddr_next;
    logic        aw_full_reg, aw_full_next;
    logic [31:0] wdata_reg,   wdata_next;
    logic [3:0]  wstrb_reg,   wstrb_next;
    logic        w_full_reg,  w_full_next;
    logic        bvalid_reg,  bvalid_next;
    logic [1:0]  bresp_reg,   bresp_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic [1:0]  rresp_reg,   rresp_next;
    logic        rvalid_reg,  rvalid_next;

    logic [15:0]          ctrl_reg,  ctrl_next;
    logic [7:0]           page_reg,  page_next;
    frps_pkg::frps_key_e  key_reg,   key_next;
    frps_pkg::frps_seq_e  seq_reg,   seq_next;
    logic                 ignored_reg, ignored_next;
    logic                 tmr_load;
    logic [15:0]          tmr_count;
    logic                 tmr_busy;
    logic                 tmr_done;
    logic                 do_write;
    logic                 start_req;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a[7:2] == ofs[7:2]);
    endfunction : is_reg

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;

    frps_timer #(
        .WIDTH (16)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (tmr_load),
        .count   (tmr_count),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // ==========================================================
    // Bus and sequencer next state
    always_comb
    begin
        awaddr_next  = awaddr_reg;
        aw_full_next = aw_full_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        w_full_next  = w_full_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        rvalid_next  = rvalid_reg;
        ctrl_next    = ctrl_reg;
        page_next    = page_reg;
        key_next     = key_reg;
        seq_next     = seq_reg;
        ignored_next = ignored_reg;
        tmr_load     = 1'b0;
        tmr_count    = 16'h0000;
        start_req    = 1'b0;

        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_next  = s_axi_awaddr;
            aw_full_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
            w_full_next = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end

        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = frps_pkg::RESP_OKAY;
            // Any write other than the second key breaks the unlock
            key_next     = frps_pkg::KEY_IDLE;
            if (is_reg(awaddr_reg, frps_pkg::CTRL_OFS))
            begin
                if (seq_reg == frps_pkg::SEQ_IDLE)
                begin
                    if (wstrb_reg[0])
                    begin
                        ctrl_next[7:0] = wdata_reg[7:0] & frps_pkg::CTRL_WR_MASK[7:0];
                    end
                    if (wstrb_reg[1])
                    begin
                        ctrl_next[14:8] = wdata_reg[14:8] & frps_pkg::CTRL_WR_MASK[14:8];
                        start_req       = wdata_reg[frps_pkg::START_BIT];
                    end
                end
            end
            else if (is_reg(awaddr_reg, frps_pkg::KEY_OFS))
            begin
                if (wstrb_reg[0] && wdata_reg[7:0] == frps_pkg::KEY_FIRST)
                begin
                    key_next = frps_pkg::KEY_HALF;
                end
                else if (wstrb_reg[0] && wdata_reg[7:0] == frps_pkg::KEY_SECOND
                         && key_reg == frps_pkg::KEY_HALF)
                begin
                    key_next = frps_pkg::KEY_ARMED;
                end
            end
            else if (is_reg(awaddr_reg, frps_pkg::PAGE_OFS))
            begin
                if (wstrb_reg[0] && seq_reg == frps_pkg::SEQ_IDLE)
                begin
                    page_next = wdata_reg[7:0];
                end
            end
            else if (!is_reg(awaddr_reg, frps_pkg::STATUS_OFS))
            begin
                bresp_next = frps_pkg::RESP_SLVERR;
            end
        end

        case (seq_reg)
            frps_pkg::SEQ_IDLE:
            begin
                if (start_req)
                begin
                    if (key_reg == frps_pkg::KEY_ARMED
                        && ctrl_next[frps_pkg::MODIFY_EN_BIT]
                        && ctrl_next[frps_pkg::ERASE_BIT]
                        && ctrl_next[3:0] == frps_pkg::OP_ERASE_PAGE)
                    begin
                        seq_next                       = frps_pkg::SEQ_ERASE;
                        ctrl_next[frps_pkg::START_BIT] = 1'b1;
                        tmr_load                       = 1'b1;
                        tmr_count                      = 16'(ERASE_CYCLES);
                        ignored_next                   = 1'b0;
                    end
                    else if (key_reg == frps_pkg::KEY_ARMED
                             && ctrl_next[frps_pkg::MODIFY_EN_BIT]
                             && !ctrl_next[frps_pkg::ERASE_BIT]
                             && ctrl_next[3:0] == frps_pkg::OP_PROGRAM_ROW)
                    begin
                        seq_next                       = frps_pkg::SEQ_PROG;
                        ctrl_next[frps_pkg::START_BIT] = 1'b1;
                        tmr_load                       = 1'b1;
                        tmr_count                      = 16'(PROG_CYCLES);
                        ignored_next                   = 1'b0;
                    end
                    else
                    begin
                        ignored_next = 1'b1;
                    end
                end
            end
            frps_pkg::SEQ_ERASE, frps_pkg::SEQ_PROG:
            begin
                if (tmr_done)
                begin
                    seq_next                       = frps_pkg::SEQ_IDLE;
                    ctrl_next[frps_pkg::START_BIT] = 1'b0;
                end
            end
            default:
            begin
                seq_next = frps_pkg::SEQ_IDLE;
            end
        endcase

        if (s_axi_rvalid && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next  = frps_pkg::RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            if (is_reg(s_axi_araddr, frps_pkg::CTRL_OFS))
            begin
                rdata_next[15:0] = ctrl_reg;
            end
            else if (is_reg(s_axi_araddr, frps_pkg::KEY_OFS))
            begin
                rdata_next = 32'h0000_0000;
            end
            else if (is_reg(s_axi_araddr, frps_pkg::PAGE_OFS))
            begin
                rdata_next[7:0] = page_reg;
            end
            else if (is_reg(s_axi_araddr, frps_pkg::STATUS_OFS))
            begin
                rdata_next[3:0] = {ignored_reg, key_reg == frps_pkg::KEY_ARMED,
                                   seq_reg == frps_pkg::SEQ_PROG,
                                   seq_reg == frps_pkg::SEQ_ERASE};
            end
            else
            begin
                rresp_next = frps_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_reg  <= 8'h00;
            aw_full_reg <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= frps_pkg::RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= frps_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            ctrl_reg    <= frps_pkg::CTRL_RESET;
            page_reg    <= frps_pkg::PAGE_RESET;
            key_reg     <= frps_pkg::KEY_IDLE;
            seq_reg     <= frps_pkg::SEQ_IDLE;
            ignored_reg <= 1'b0;
        end
        else
        begin
            awaddr_reg  <= awaddr_next;
            aw_full_reg <= aw_full_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            w_full_reg  <= w_full_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            rvalid_reg  <= rvalid_next;
            ctrl_reg    <= ctrl_next;
            page_reg    <= page_next;
            key_reg     <= key_next;
            seq_reg     <= seq_next;
            ignored_reg <= ignored_next;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;
    assign cpu_stall         = (seq_reg != frps_pkg::SEQ_IDLE);
    assign flash_erase_page  = (seq_reg == frps_pkg::SEQ_ERASE);
    assign flash_program_row = (seq_reg == frps_pkg::SEQ_PROG);
    assign flash_page        = page_reg;
endmodule : frps_sequencer
`default_nettype wire

// ===== dv/frps_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frps_sequencer_asserts #(
    parameter int ERASE_CYCLES = 4,
    parameter int PROG_CYCLES  = 4
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cpu_stall,
    input wire logic        flash_erase_page,
    input wire logic        flash_program_row,
    input wire logic [7:0]  flash_page
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Cycle counters for each flash operation
    logic [15:0] era_reg;
    logic [15:0] era_next;
    logic [15:0] prg_reg;
    logic [15:0] prg_next;
    always_comb
    begin
        era_next = flash_erase_page ? era_reg + 16'h0001 : 16'h0000;
        prg_next = flash_program_row ? prg_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge aclk)
    begin
        era_reg <= aresetn ? era_next : 16'h0000;
        prg_reg <= aresetn ? prg_next : 16'h0000;
    end
    // ==========================================
    // Properties
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    chk_stall_matches_op: assert property (cpu_stall == (flash_erase_page || flash_program_row))
        else $error("stall differs from flash operation");
    chk_one_op_only: assert property (!(flash_erase_page && flash_program_row))
        else $error("erase and program together");
    chk_erase_span: assert property ($fell(flash_erase_page) |-> era_reg == ERASE_CYCLES + 1)
        else $error("erase cycle length wrong");
    chk_prog_span: assert property ($fell(flash_program_row) |-> prg_reg == PROG_CYCLES + 1)
        else $error("program cycle length wrong");
    chk_start_on_write: assert property ($rose(cpu_stall) |-> $rose(s_axi_bvalid))
        else $error("stall began without a write");
    chk_page_frozen: assert property (cpu_stall ##1 cpu_stall |-> $stable(flash_page))
        else $error("page moved during cycle");
    chk_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_no_take_on_b: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule : frps_sequencer_asserts
`default_nettype wire

// ===== dv/frps_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module frps_sequencer_tb;
    localparam int         ERA = 12;
    localparam int         PRG = 6;
    localparam logic [7:0] A_CTRL = frps_pkg::CTRL_OFS;
    localparam logic [7:0] A_KEY = frps_pkg::KEY_OFS;
    localparam logic [7:0] A_PAGE = frps_pkg::PAGE_OFS;
    localparam logic [7:0] A_STAT = frps_pkg::STATUS_OFS;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, page, last_page, pg;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, stall, er, pr;
    logic [1:0]  bresp, rresp, resp, last_kind;
    logic [15:0] c;
    int          errors = 0, checks = 0, starts = 0, run = 0, last_len = 0;

    always #20 aclk = ~aclk;

    frps_sequencer #(.ERASE_CYCLES(ERA), .PROG_CYCLES(PRG)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_stall(stall), .flash_erase_page(er), .flash_program_row(pr), .flash_page(page)
    );

    // ==========================================
    // Stall monitor
    always @(negedge aclk)
    begin
        if (stall === 1'b1)
        begin
            run++;
            last_kind = {er, pr};
            last_page = page;
        end
        else if (run > 0)
        begin
            last_len = run;
            starts++;
            run = 0;
        end
    end

    // ==========================================
    // Checking and bus tasks
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        while (tb !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        while (tr !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    function automatic bit start_ok(logic [15:0] f, logic [7:0] k1, logic [7:0] k2, bit gap);
        return f[14] && k1 == 8'h55 && k2 == 8'hAA && !gap
            && ((f[3:0] == frps_pkg::OP_ERASE_PAGE && f[6])
            || (f[3:0] == frps_pkg::OP_PROGRAM_ROW && !f[6]));
    endfunction : start_ok

    task automatic set_page(input logic [7:0] p);
        wr(A_PAGE, {24'h0, p});
        rd(A_PAGE, d);
        check("page", d, {24'h0, p});
    endtask : set_page

    // Config, two keys, optional stray write, start; poke writes page mid-cycle
    task automatic try_start(input logic [15:0] f, input logic [7:0] k1, input logic [7:0] k2,
                             input bit gap, input bit poke);
        int s0;
        bit ok;
        ok = start_ok(f, k1, k2, gap);
        rd(A_PAGE, d);
        pg = d[7:0];
        wr(A_CTRL, {16'h0, f});
        wr(A_KEY, {24'h0, k1});
        if (gap) wr(A_PAGE, d);
        wr(A_KEY, {24'h0, k2});
        rd(A_STAT, d);
        check("armed", d[2], k1 == 8'h55 && k2 == 8'hAA && !gap);
        s0 = starts;
        wr(A_CTRL, {16'h0, f | 16'h8000});
        check("start resp", resp, frps_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        rd(A_STAT, d);
        check("busy kind", d[1:0], ok ? (f[6] ? 2'b01 : 2'b10) : 2'b00);
        if (poke) wr(A_PAGE, {24'h0, ~pg});
        @(negedge aclk);
        while (stall === 1'b1) @(negedge aclk);
        @(negedge aclk);
        check("started", starts - s0, ok);
        if (ok)
        begin
            check("stall len", last_len, (f[6] ? ERA : PRG) + 1);
            check("op kind", last_kind, f[6] ? 2'b10 : 2'b01);
            check("op page", last_page, pg);
        end
        rd(A_CTRL, d);
        check("ctrl", d, {16'h0, f & frps_pkg::CTRL_WR_MASK});
        rd(A_STAT, d);
        check("ignored flag", d[3], !ok);
        rd(A_PAGE, d);
        check("page kept", d, {24'h0, pg});
    endtask : try_start

    // ==========================================
    // Tests
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        $display("watchdog expired");
        end_of_test();
    end

    initial
    begin
        void'($urandom(81));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd(i == 0 ? A_CTRL : i == 1 ? A_KEY : i == 2 ? A_PAGE : A_STAT, d);
            check("reset value", d, 32'h0);
        end
        rd(8'h10, d);
        check("unmapped resp", resp, frps_pkg::RESP_SLVERR);
        $display("test reset done");
        set_page(8'($urandom));
        try_start(16'h4042, 8'h55, 8'hAA, 1'b0, 1'b1);
        $display("test erase done");
        for (int i = 0; i < frps_pkg::PAGE_ROWS; i++)
        begin
            set_page(pg + 8'(i > 0));
            try_start(16'h4001, 8'h55, 8'hAA, 1'b0, 1'b0);
        end
        $display("test rows done");
        try_start(16'h0042, 8'h55, 8'hAA, 1'b0, 1'b0);
        try_start(16'h4042, 8'hAA, 8'h55, 1'b0, 1'b0);
        try_start(16'h4001, 8'h55, 8'hAA, 1'b1, 1'b0);
        try_start(16'h4041, 8'h55, 8'hAA, 1'b0, 1'b0);
        try_start(16'h4002, 8'h55, 8'hAA, 1'b0, 1'b0);
        $display("test refusals done");
        repeat (25)
        begin
            c = 16'($urandom) & 16'h3FB0;
            c[3:0] = 4'($urandom_range(0, 3));
            c[6] = 1'($urandom_range(0, 1));
            c[14] = $urandom_range(0, 3) != 0;
            set_page(8'($urandom));
            try_start(c, $urandom_range(0, 4) ? 8'h55 : 8'($urandom),
                      $urandom_range(0, 4) ? 8'hAA : 8'($urandom),
                      $urandom_range(0, 5) == 0, 1'b0);
        end
        $display("test random done");
        end_of_test();
    end
endmodule : frps_sequencer_tb

bind frps_sequencer frps_sequencer_asserts #(
    .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)
) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_stall(cpu_stall), .flash_erase_page(flash_erase_page),
    .flash_program_row(flash_program_row), .flash_page(flash_page)
);
`default_nettype wire
